// >>> design/ptoi_pkg.sv
package ptoi_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int START_MIN_NS = 1000;
    localparam int START_MIN_CYC = (START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESP_MAX_NS = 50;
    localparam int RESP_MAX_CYC = (RESP_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : (RESP_MAX_NS / CLK_PERIOD_NS);
    localparam int RET_PULSE_NS = 1000;
    localparam int RET_PULSE_CYC = RET_PULSE_NS / CLK_PERIOD_NS;
    localparam int SER_TIMEOUT_NS = 20000;
    localparam int SER_TIMEOUT_CYC = SER_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int INT_GAP_CYC = 16;
    // ****************************************
    // Widths and codes
    // ****************************************
    localparam int POS_W = 16;
    localparam int CNT_W = 16;
    localparam int SER_W = 26;
    localparam int SLEN_W = 5;
    localparam logic [1:0] SLEN_24 = 2'h0;
    localparam logic [1:0] SLEN_25 = 2'h1;
    localparam logic [4:0] SER_LEN_24 = 5'h18;
    localparam logic [4:0] SER_LEN_25 = 5'h19;
    localparam logic [4:0] SER_LEN_26 = 5'h1A;
    typedef enum logic [2:0] {
        PTOI_MODE_PWM_EXT = 3'b000,
        PTOI_MODE_PWM_INT = 3'b001,
        PTOI_MODE_CTRL = 3'b010,
        PTOI_MODE_DIFF = 3'b011,
        PTOI_MODE_TTL = 3'b100,
        PTOI_MODE_QUAD = 3'b101,
        PTOI_MODE_SER = 3'b110
    } ptoi_mode_type;
    typedef enum logic [1:0] {
        PTOI_ST_IDLE = 2'b00,
        PTOI_ST_MEAS = 2'b01,
        PTOI_ST_STOP = 2'b10,
        PTOI_ST_GAP = 2'b11
    } ptoi_state_type;
endpackage

// >>> design/ptoi_sync.sv
module ptoi_sync (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Data
    input wire logic i_async,
    output logic o_sync
);
    logic meta;
    logic next_meta;
    logic next_sync;

    always_comb begin
        next_meta = i_ce ? i_async : meta;
        next_sync = i_ce ? meta : o_sync;
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta <= next_meta;
            o_sync <= next_sync;
        end
    end
endmodule

// >>> design/ptoi_top.sv
// Operation
// - Pulse-width output starts within 50 ns of start leading edge.
// - Pulse-width output width is proportional to magnet distance.
// - Internal interrogation repeats pulse-width output with no start pulse.
// - Control-pulse stop edge follows start edge by distance-proportional time.
// - Differential variant returns two 1 us pulses, spaced by distance; a spacing under 1 us merges them into one.
// - TTL variant emits one stop pulse after a valid 1 us start.
// - Quadrature mode drives A, B and index as complementary pairs.
// - Logic 0 on a quadrature channel means plus above minus.
// - Serial word is 24, 25 or 26 bits by configuration.
// - One position bit is shifted out per serial clock pulse.
// - Position keeps updating and loads into the serial shift register.
module ptoi_top (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Configuration
    input wire ptoi_pkg::ptoi_mode_type i_mode,
    input wire logic [1:0] i_ser_len,
    // Position source
    input wire logic [ptoi_pkg::POS_W-1:0] i_position,
    // Interrogation and serial clock pins
    input wire logic i_start,
    input wire logic i_ser_clk,
    // Pulse outputs
    output logic o_pulse_p,
    output logic o_pulse_n,
    // Quadrature pairs
    output logic o_qa_p,
    output logic o_qa_n,
    output logic o_qb_p,
    output logic o_qb_n,
    output logic o_qz_p,
    output logic o_qz_n,
    // Serial data
    output logic o_ser_data
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    logic start_s;
    logic sclk_s;
    ptoi_sync u_sync_start (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_async(i_start),
        .o_sync(start_s)
    );

    ptoi_sync u_sync_sclk (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_async(i_ser_clk),
        .o_sync(sclk_s)
    );

    // ****************************************
    // Edge detection and position sampling
    // ****************************************
    logic start_d, sclk_d, next_start_d, next_sclk_d;
    logic [ptoi_pkg::POS_W-1:0] pos, next_pos;
    logic start_rise, sclk_fall, sclk_rise;
    always_comb begin
        next_start_d = i_ce ? start_s : start_d;
        next_sclk_d = i_ce ? sclk_s : sclk_d;
        next_pos = i_ce ? i_position : pos;
    end
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            start_d <= 1'b0;
            sclk_d <= 1'b0; // Same as the cleared synchroniser: no false fall after reset
            pos <= '0;
        end else begin
            start_d <= next_start_d;
            sclk_d <= next_sclk_d;
            pos <= next_pos;
        end
    end
    assign start_rise = start_s && !start_d;
    assign sclk_fall = !sclk_s && sclk_d;
    assign sclk_rise = sclk_s && !sclk_d;

    // ****************************************
    // Pulse modes
    // ****************************************
    // Start is acted on at its leading edge so the pulse-width output meets the
    // short response bound; the width check only gates the stop-type modes.
    ptoi_pkg::ptoi_state_type state, next_state;
    logic [ptoi_pkg::CNT_W-1:0] cnt, next_cnt, hi_cnt, next_hi_cnt, pw_len, next_pw_len;
    logic pulse, next_pulse, is_pwm, is_stop_mode, start_ok;
    localparam logic [ptoi_pkg::CNT_W-1:0] RET_CYC = ptoi_pkg::CNT_W'(ptoi_pkg::RET_PULSE_CYC);
    localparam logic [ptoi_pkg::CNT_W-1:0] MIN_CYC = ptoi_pkg::CNT_W'(ptoi_pkg::START_MIN_CYC);
    localparam logic [ptoi_pkg::CNT_W-1:0] GAP_CYC = ptoi_pkg::CNT_W'(ptoi_pkg::INT_GAP_CYC);
    assign is_pwm = (i_mode == ptoi_pkg::PTOI_MODE_PWM_EXT) ||
                    (i_mode == ptoi_pkg::PTOI_MODE_PWM_INT);
    assign is_stop_mode = (i_mode == ptoi_pkg::PTOI_MODE_CTRL) ||
                          (i_mode == ptoi_pkg::PTOI_MODE_DIFF) ||
                          (i_mode == ptoi_pkg::PTOI_MODE_TTL);
    assign start_ok = start_s && (hi_cnt == MIN_CYC - 16'h0001);
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_pulse = pulse;
        next_pw_len = pw_len;
        next_hi_cnt = start_s ? ((hi_cnt == MIN_CYC) ? hi_cnt : hi_cnt + 16'h0001) : '0;
        case (state)
            ptoi_pkg::PTOI_ST_IDLE: begin
                if ((i_mode == ptoi_pkg::PTOI_MODE_PWM_EXT) && start_rise) begin
                    next_pulse = 1'b1;
                    next_pw_len = (pos == '0) ? 16'h0001 : pos;
                    next_cnt = 16'h0001;
                    next_state = ptoi_pkg::PTOI_ST_MEAS;
                end else if (i_mode == ptoi_pkg::PTOI_MODE_PWM_INT) begin
                    next_pulse = 1'b1;
                    next_pw_len = (pos == '0) ? 16'h0001 : pos;
                    next_cnt = 16'h0001;
                    next_state = ptoi_pkg::PTOI_ST_MEAS;
                end else if (is_stop_mode && start_ok) begin
                    // Measure from the start leading edge, already MIN_CYC ago
                    next_cnt = MIN_CYC;
                    next_pw_len = pos;
                    next_pulse = (i_mode == ptoi_pkg::PTOI_MODE_DIFF);
                    next_state = ptoi_pkg::PTOI_ST_MEAS;
                end
            end
            ptoi_pkg::PTOI_ST_MEAS: begin
                next_cnt = cnt + 16'h0001;
                if (is_pwm) begin
                    if (cnt >= pw_len) begin
                        next_pulse = 1'b0;
                        next_cnt = '0;
                        next_state = ptoi_pkg::PTOI_ST_GAP;
                    end
                end else begin
                    // First return pulse began at acceptance, with cnt at MIN_CYC
                    if ((i_mode == ptoi_pkg::PTOI_MODE_DIFF) &&
                        (cnt >= MIN_CYC + RET_CYC - 16'h0001)) begin
                        next_pulse = 1'b0;
                    end
                    // A position under one pulse width merges the two differential pulses
                    if (cnt >= pw_len + MIN_CYC) begin
                        next_pulse = 1'b1;
                        next_cnt = 16'h0001;
                        next_state = ptoi_pkg::PTOI_ST_STOP;
                    end
                end
            end
            ptoi_pkg::PTOI_ST_STOP: begin
                next_cnt = cnt + 16'h0001;
                if (cnt >= RET_CYC) begin
                    next_pulse = 1'b0;
                    next_cnt = '0;
                    next_state = ptoi_pkg::PTOI_ST_GAP;
                end
            end
            ptoi_pkg::PTOI_ST_GAP: begin
                next_cnt = cnt + 16'h0001;
                if ((cnt >= GAP_CYC) && !start_s) begin
                    next_state = ptoi_pkg::PTOI_ST_IDLE;
                end
            end
            default: begin
                next_state = ptoi_pkg::PTOI_ST_IDLE;
                next_pulse = 1'b0;
            end
        endcase
        if (!is_pwm && !is_stop_mode) begin
            next_state = ptoi_pkg::PTOI_ST_IDLE;
            next_pulse = 1'b0;
        end
    end
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= ptoi_pkg::PTOI_ST_IDLE;
            cnt <= '0;
            hi_cnt <= '0;
            pw_len <= '0;
            pulse <= 1'b0;
        end else if (i_ce) begin
            state <= next_state;
            cnt <= next_cnt;
            hi_cnt <= next_hi_cnt;
            pw_len <= next_pw_len;
            pulse <= next_pulse;
        end
    end
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pulse_p <= 1'b0;
            o_pulse_n <= 1'b1;
        end else if (i_ce) begin
            o_pulse_p <= next_pulse;
            o_pulse_n <= !next_pulse;
        end
    end

    // ****************************************
    // Quadrature
    // ****************************************
    // Follows position one count per clock; a big jump takes many cycles.
    logic [ptoi_pkg::POS_W-1:0] qpos, next_qpos;
    logic [2:0] quad, next_quad;
    always_comb begin
        next_qpos = qpos;
        if (i_mode == ptoi_pkg::PTOI_MODE_QUAD) begin
            if (pos > qpos) begin
                next_qpos = qpos + 16'h0001;
            end else if (pos < qpos) begin
                next_qpos = qpos - 16'h0001;
            end
        end
        next_quad[0] = next_qpos[1] ^ next_qpos[0]; // Phase A
        next_quad[1] = next_qpos[1]; // Phase B
        next_quad[2] = (next_qpos == '0); // Index at zero
    end
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            qpos <= '0;
            quad <= 3'h0;
            o_qa_p <= 1'b1;
            o_qa_n <= 1'b0;
            o_qb_p <= 1'b1;
            o_qb_n <= 1'b0;
            o_qz_p <= 1'b1;
            o_qz_n <= 1'b0;
        end else if (i_ce) begin
            qpos <= next_qpos;
            quad <= next_quad;
            o_qa_p <= !next_quad[0];
            o_qa_n <= next_quad[0];
            o_qb_p <= !next_quad[1];
            o_qb_n <= next_quad[1];
            o_qz_p <= !next_quad[2];
            o_qz_n <= next_quad[2];
        end
    end

    // ****************************************
    // Serial
    // ****************************************
    logic [ptoi_pkg::SER_W-1:0] shreg, next_shreg;
    logic [ptoi_pkg::SLEN_W-1:0] bits_left, next_bits_left, word_len;
    logic [ptoi_pkg::CNT_W-1:0] idle_cnt, next_idle_cnt;
    logic in_frame, next_in_frame, ser_out, next_ser_out;
    localparam logic [ptoi_pkg::CNT_W-1:0] TO_CYC = ptoi_pkg::CNT_W'(ptoi_pkg::SER_TIMEOUT_CYC);
    always_comb begin
        case (i_ser_len)
            ptoi_pkg::SLEN_24: word_len = ptoi_pkg::SER_LEN_24;
            ptoi_pkg::SLEN_25: word_len = ptoi_pkg::SER_LEN_25;
            default: word_len = ptoi_pkg::SER_LEN_26;
        endcase
    end
    always_comb begin
        next_shreg = shreg;
        next_bits_left = bits_left;
        next_in_frame = in_frame;
        next_ser_out = ser_out;
        next_idle_cnt = (sclk_s && (idle_cnt != TO_CYC)) ? idle_cnt + 16'h0001 :
                        (sclk_s ? idle_cnt : '0);
        if (i_mode != ptoi_pkg::PTOI_MODE_SER) begin
            next_in_frame = 1'b0;
            next_ser_out = 1'b1;
        end else if (sclk_fall && !in_frame) begin
            // Position right-aligned in the word, loaded at frame start
            next_shreg = ptoi_pkg::SER_W'(pos) << (ptoi_pkg::SER_W[4:0] - word_len);
            next_bits_left = word_len;
            next_in_frame = 1'b1;
        end else if (in_frame && sclk_rise) begin
            if (bits_left != '0) begin
                next_ser_out = shreg[ptoi_pkg::SER_W-1];
                next_shreg = {shreg[ptoi_pkg::SER_W-2:0], 1'b0};
                next_bits_left = bits_left - 5'h01;
            end else begin
                next_ser_out = 1'b0;
            end
        end else if (in_frame && (idle_cnt == TO_CYC)) begin
            // Clock idle high long enough: frame ends, line returns high
            next_in_frame = 1'b0;
            next_ser_out = 1'b1;
        end
    end
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            shreg <= '0;
            bits_left <= '0;
            in_frame <= 1'b0;
            ser_out <= 1'b1;
            idle_cnt <= '0;
            o_ser_data <= 1'b1;
        end else if (i_ce) begin
            shreg <= next_shreg;
            bits_left <= next_bits_left;
            in_frame <= next_in_frame;
            ser_out <= next_ser_out;
            idle_cnt <= next_idle_cnt;
            o_ser_data <= next_ser_out;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_pwm_start_resp: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_ce && state == ptoi_pkg::PTOI_ST_IDLE && i_mode == ptoi_pkg::PTOI_MODE_PWM_EXT
         && start_rise) |=> o_pulse_p)
        else $error("pulse output late after start");
    a_quad_pair_comp: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (o_qa_p != o_qa_n) && (o_qb_p != o_qb_n) && (o_qz_p != o_qz_n))
        else $error("quadrature pair not complementary");
    a_quad_zero_level: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_ce |=> (o_qa_p == !quad[0]) && (o_qb_p == !quad[1]) &&
                 (quad[0] == (qpos[1] ^ qpos[0])))
        else $error("quadrature logic level wrong");
    a_ser_len_load: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_ce && i_mode == ptoi_pkg::PTOI_MODE_SER && sclk_fall && !in_frame)
        |=> (bits_left == $past(word_len)))
        else $error("serial length not loaded");
    a_ser_bit_step: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_ce && i_mode == ptoi_pkg::PTOI_MODE_SER && in_frame && sclk_rise && bits_left != '0)
        |=> (bits_left == $past(bits_left) - 5'h01))
        else $error("serial bit count not stepped");
    a_ser_msb_first: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_ce && i_mode == ptoi_pkg::PTOI_MODE_SER && in_frame && sclk_rise && bits_left != '0)
        |=> ##1 (o_ser_data == $past(shreg[ptoi_pkg::SER_W-1], 2)))
        else $error("serial bit not msb first");
    a_pos_track: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_ce |=> (pos == $past(i_position)))
        else $error("position not updated");
    a_pwm_int_run: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_ce && state == ptoi_pkg::PTOI_ST_IDLE && i_mode == ptoi_pkg::PTOI_MODE_PWM_INT)
        |=> (state == ptoi_pkg::PTOI_ST_MEAS && pulse))
        else $error("internal interrogation stalled");
endmodule

// >>> verification/ptoi_ctrl_model.sv
module ptoi_ctrl_model (
    // Clock
    input wire logic i_clk,
    // Device outputs
    input wire logic i_ser_data,
    // Controller drives
    output logic o_start,
    output logic o_ser_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Controller side of the pins
    // ****************************************
    // Half of the 160 ns serial clock; the 3 ns lead keeps it off the main clock grid
    localparam int HALF_NS = 80;
    initial begin
        o_start = 1'b0;
        o_ser_clk = 1'b1;
    end

    // Caller picks the hold; a hold below one microsecond is a deliberate fault
    task automatic start_pulse(input int hold);
        o_start = 1'b1;
        repeat (hold) @(negedge i_clk);
        o_start = 1'b0;
    endtask

    // Clock stands high between frames; each bit is taken at the next falling edge
    task automatic read_frame(input int nbits, output logic [31:0] word);
        word = 32'h0;
        #3;
        o_ser_clk = 1'b0;
        for (int k = 0; k < nbits; k++) begin
            #HALF_NS o_ser_clk = 1'b1;
            #HALF_NS word = {word[30:0], i_ser_data};
            o_ser_clk = 1'b0;
        end
        #HALF_NS o_ser_clk = 1'b1;
    endtask
endmodule

// >>> verification/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Signals
    // ****************************************
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_ce = 1'b1;
    ptoi_pkg::ptoi_mode_type i_mode = ptoi_pkg::PTOI_MODE_PWM_EXT;
    logic [1:0] i_ser_len = 2'h0;
    logic [ptoi_pkg::POS_W-1:0] i_position = 16'h0001;
    logic i_start;
    logic i_ser_clk;
    logic o_pulse_p, o_pulse_n, o_ser_data;
    logic o_qa_p, o_qa_n, o_qb_p, o_qb_n, o_qz_p, o_qz_n;
    logic [31:0] seed = 32'h4B71AEBC;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;

    ptoi_top ptoi_top_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_mode(i_mode),
        .i_ser_len(i_ser_len), .i_position(i_position), .i_start(i_start),
        .i_ser_clk(i_ser_clk), .o_pulse_p(o_pulse_p), .o_pulse_n(o_pulse_n),
        .o_qa_p(o_qa_p), .o_qa_n(o_qa_n), .o_qb_p(o_qb_p), .o_qb_n(o_qb_n),
        .o_qz_p(o_qz_p), .o_qz_n(o_qz_n), .o_ser_data(o_ser_data));
    ptoi_ctrl_model ptoi_ctrl_model_i (.i_clk(i_clk), .i_ser_data(o_ser_data),
        .o_start(i_start), .o_ser_clk(i_ser_clk));

    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) cyc <= cyc + 1;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t ns: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic chk_in(input int v, input int lo, input int hi);
        n_checks++;
        if (v < lo || v > hi) begin
            bad_count++;
            $display("ERROR at %0t ns: got %0h expected %0h to %0h", $time, v, lo, hi);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Mode is only changed under reset, so no mode switch lands mid-pulse
    task automatic do_reset(input ptoi_pkg::ptoi_mode_type m);
        @(negedge i_clk);
        i_nrst = 1'b0;
        i_mode = m;
        repeat (16) @(negedge i_clk);
        i_nrst = 1'b1;
        repeat (4) @(negedge i_clk);
    endtask

    // Rise is the cycle count at the first high sample, width counts high samples
    task automatic measure(input int limit, output int rise, output int wid);
        rise = -1;
        wid = 0;
        for (int k = 0; k < limit && rise < 0; k++) begin
            @(negedge i_clk);
            if (o_pulse_p === 1'b1) rise = cyc;
        end
        if (rise >= 0) begin
            chk({31'h0, o_pulse_n}, 32'h0);
            while (o_pulse_p === 1'b1 && wid < limit) begin
                wid++;
                @(negedge i_clk);
            end
        end
    endtask

    task automatic interrogate(input int hold, input int limit,
                               output int t0, output int rise, output int wid);
        @(negedge i_clk);
        t0 = cyc;
        fork
            ptoi_ctrl_model_i.start_pulse(hold);
            measure(limit, rise, wid);
        join
        repeat (40) @(negedge i_clk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        int p, t0, r1, w1, r2, w2, n;
        logic [31:0] word;
        logic a, b, z;
        do_reset(ptoi_pkg::PTOI_MODE_PWM_EXT);
        for (int k = 0; k < 4; k++) begin
            p = (k == 0) ? 1 : int'(xs() % 200) + 1;
            i_position = 16'(p);
            interrogate(110, 400, t0, r1, w1);
            chk_in(r1 - t0, 1, 4);
            chk(32'(w1), 32'(p));
            chk({31'h0, o_pulse_n}, 32'h1);
        end
        for (int m = 0; m < 2; m++) begin
            do_reset(m == 0 ? ptoi_pkg::PTOI_MODE_CTRL : ptoi_pkg::PTOI_MODE_TTL);
            p = int'(xs() % 300);
            i_position = 16'(p);
            interrogate(110, p + 300, t0, r1, w1);
            chk_in(r1 - t0, p + 100, p + 106);
            chk(32'(w1), 32'(ptoi_pkg::RET_PULSE_CYC));
            interrogate(50, 500, t0, r1, w1);
            chk(32'(r1), 32'hFFFFFFFF);
        end
        do_reset(ptoi_pkg::PTOI_MODE_DIFF);
        for (int k = 0; k < 2; k++) begin
            p = 150 + int'(xs() % 250);
            i_position = 16'(p);
            @(negedge i_clk);
            fork
                ptoi_ctrl_model_i.start_pulse(110);
                begin
                    measure(400, r1, w1);
                    measure(p + 200, r2, w2);
                end
            join
            repeat (40) @(negedge i_clk);
            chk(32'(w1), 32'(ptoi_pkg::RET_PULSE_CYC));
            chk(32'(w2), 32'(ptoi_pkg::RET_PULSE_CYC));
            chk_in(r2 - r1, p - 3, p + 3);
        end
        do_reset(ptoi_pkg::PTOI_MODE_QUAD);
        for (int k = 0; k < 8; k++) begin
            p = (k < 4) ? k : int'(xs() % 1024);
            i_position = 16'(p);
            repeat (1100) @(negedge i_clk);
            a = i_position[1] ^ i_position[0];
            b = i_position[1];
            z = (p == 0);
            chk({26'h0, o_qa_p, o_qa_n, o_qb_p, o_qb_n, o_qz_p, o_qz_n},
                {26'h0, ~a, a, ~b, b, ~z, z});
        end
        // Clock enable low freezes the follower even though the position moves
        i_ce = 1'b0;
        i_position = 16'h0000;
        repeat (20) @(negedge i_clk);
        chk({29'h0, o_qa_p, o_qb_p, o_qz_p}, {29'h0, ~a, ~b, ~z});
        i_ce = 1'b1;
        do_reset(ptoi_pkg::PTOI_MODE_SER);
        for (int k = 0; k < 4; k++) begin
            i_ser_len = 2'(k);
            n = (k == 0) ? 24 : (k == 1) ? 25 : 26;
            p = int'(xs() & 32'h0000FFFF);
            i_position = 16'(p);
            repeat (10) @(negedge i_clk);
            fork
                ptoi_ctrl_model_i.read_frame(n, word);
                begin
                    repeat (20) @(negedge i_clk);
                    i_position = ~16'(p);
                end
            join
            chk(word, 32'(p));
            repeat (8) @(negedge i_clk);
            chk({31'h0, o_ser_data}, 32'h0);
            repeat (ptoi_pkg::SER_TIMEOUT_CYC + 50) @(negedge i_clk);
            chk({31'h0, o_ser_data}, 32'h1);
        end
        p = int'(xs() % 100) + 1;
        i_position = 16'(p);
        do_reset(ptoi_pkg::PTOI_MODE_PWM_INT);
        for (int k = 0; k < 3; k++) begin
            measure(p + 80, r1, w1);
            chk(32'(w1), 32'(p));
        end
        report_and_stop();
    end

    // Scenarios need roughly 23000 cycles; over twice that means a hang
    initial begin
        repeat (60000) @(posedge i_clk);
        bad_count++;
        report_and_stop();
    end
endmodule
